//--- pkg/quad_timer_pkg.sv
// Package for the quad timer/counter block: register indexes, field
// positions, reset values and timing counts.
// Assumes a 10 MHz system clock and a register bus with byte address = 4 * index.
package quad_timer_pkg;

   // Register indexes; byte address on the bus is four times the index
   localparam logic [7:0] IDX_RUN_FLAG_CTRL  = 8'h88;
   localparam logic [7:0] IDX_MODE_SELECT    = 8'h89;
   localparam logic [7:0] IDX_T0_COUNT_LOW   = 8'h8A;
   localparam logic [7:0] IDX_T1_COUNT_LOW   = 8'h8B;
   localparam logic [7:0] IDX_T0_COUNT_HIGH  = 8'h8C;
   localparam logic [7:0] IDX_T1_COUNT_HIGH  = 8'h8D;
   localparam logic [7:0] IDX_PIN_OUT_ENABLE = 8'h93;
   localparam logic [7:0] IDX_MISC_OPTION    = 8'h94;
   localparam logic [7:0] IDX_SHARED_FLAGS   = 8'h95;
   localparam logic [7:0] IDX_T2_CONTROL     = 8'hC8;
   localparam logic [7:0] IDX_T2_RCAP_LOW    = 8'hCA;
   localparam logic [7:0] IDX_T2_RCAP_HIGH   = 8'hCB;
   localparam logic [7:0] IDX_T2_COUNT_LOW   = 8'hCC;
   localparam logic [7:0] IDX_T2_COUNT_HIGH  = 8'hCD;
   localparam logic [7:0] IDX_AUX_CONTROL    = 8'hF8;

   // Reset values
   localparam logic [7:0] RST_BYTE_ZERO      = 8'h00;
   localparam logic [7:0] RST_AUX_CONTROL    = 8'h0C;

   // Run/flag control fields
   localparam int BIT_T1_OVF_FLAG  = 7;
   localparam int BIT_T1_RUN       = 6;
   localparam int BIT_T0_OVF_FLAG  = 5;
   localparam int BIT_T0_RUN       = 4;
   // Mode select fields
   localparam int BIT_T1_GATING    = 7;
   localparam int BIT_T1_COUNT_SEL = 6;
   localparam int LSB_T1_LAYOUT    = 4;
   localparam int BIT_T0_GATING    = 3;
   localparam int BIT_T0_COUNT_SEL = 2;
   localparam int LSB_T0_LAYOUT    = 0;
   // Timer2 control fields
   localparam int BIT_T2_OVF_FLAG  = 7;
   localparam int BIT_T2_TRIG_FLAG = 6;
   localparam int BIT_RX_BAUD_T2   = 5;
   localparam int BIT_TX_BAUD_T2   = 4;
   localparam int BIT_T2_TRIG_EN   = 3;
   localparam int BIT_T2_RUN       = 2;
   localparam int BIT_T2_COUNT_SEL = 1;
   localparam int BIT_T2_CAPTURE   = 0;
   // Option, flag, aux and pin-output fields
   localparam int BIT_T3_CLK_SEL   = 6;
   localparam int LSB_T3_RATE      = 0;
   localparam int BIT_T3_FLAG      = 0;
   localparam int BIT_T3_CLEAR     = 6;
   localparam int BIT_T2_DIV2_OE   = 6;
   localparam int BIT_T0_DIV64_OE  = 4;

   // Layout encodings
   localparam logic [1:0] LAYOUT_13BIT  = 2'h0;
   localparam logic [1:0] LAYOUT_16BIT  = 2'h1;
   localparam logic [1:0] LAYOUT_RELOAD = 2'h2;
   localparam logic [1:0] LAYOUT_SPLIT  = 2'h3;

   // Timing counts
   localparam int          TIME_BASE_CYCLES = 2;
   localparam logic [4:0]  T0_OUT_HALF      = 5'h1F;
   localparam logic [8:0]  FAST_RC_DIV_LAST = 9'h1FF;
   localparam logic [16:0] T3_PERIOD_R0     = 17'h08000;
   localparam logic [16:0] T3_PERIOD_R1     = 17'h04000;
   localparam logic [16:0] T3_PERIOD_R2     = 17'h02000;
   localparam logic [16:0] T3_PERIOD_R3     = 17'h10000;

   // Synchronised pin positions
   localparam int PIN_IRQ0 = 0;
   localparam int PIN_IRQ1 = 1;
   localparam int PIN_T0   = 2;
   localparam int PIN_T1   = 3;
   localparam int PIN_T2   = 4;
   localparam int PIN_TRIG = 5;
   localparam int PIN_SLOW = 6;
   localparam int PIN_FAST = 7;
   localparam int PIN_COUNT = 8;

   // One step of an 8-bit pair timer
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } pair_step_s;

endpackage : quad_timer_pkg

//--- hw/quad_timer_counter_block.sv
// Four timers: two 8/13/16-bit pair timers, a 16-bit reload/capture timer
// and a periodic time base. Assumes Avalon-MM master, asynchronous pins.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module quad_timer_counter_block
   import quad_timer_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   input  wire logic [9:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata_q,
   output logic             o_avs_waitrequest_q,
   input  wire logic        i_ext_irq0_pin,
   input  wire logic        i_ext_irq1_pin,
   input  wire logic        i_timer0_count_pin,
   input  wire logic        i_timer1_count_pin,
   input  wire logic        i_timer2_count_pin,
   input  wire logic        i_timer2_trigger_pin,
   input  wire logic        i_slow_rc_clock,
   input  wire logic        i_fast_rc_clock,
   input  wire logic        i_timer0_vector_ack,
   input  wire logic        i_timer1_vector_ack,
   input  wire logic        i_timer3_vector_ack,
   output logic             o_timer0_overflow_flag_q,
   output logic             o_timer1_overflow_flag_q,
   output logic             o_timer2_overflow_flag_q,
   output logic             o_timer2_trigger_flag_q,
   output logic             o_timer3_period_flag_q,
   output logic             o_timer0_div64_out_q,
   output logic             o_timer0_div64_oe_q,
   output logic             o_timer2_div2_out_q,
   output logic             o_timer2_div2_oe_q,
   output logic             o_uart_rx_baud_tick_q,
   output logic             o_uart_tx_baud_tick_q
);

   function automatic pair_step_s pair_step(input logic [1:0] mode,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
      pair_step_s r;
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      r   = '{hi: hi, lo: lo, ovf: 1'b0};
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8  = {1'b0, lo} + 9'h001;
      case (mode)
         LAYOUT_13BIT: begin
            r.hi  = s13[12:5];
            r.lo  = {lo[7:5], s13[4:0]};
            r.ovf = s13[13];
         end
         LAYOUT_16BIT: begin
            r.hi  = s16[15:8];
            r.lo  = s16[7:0];
            r.ovf = s16[16];
         end
         LAYOUT_RELOAD: begin
            r.lo  = s8[8] ? hi : s8[7:0];
            r.ovf = s8[8];
         end
         default: begin
            r.lo  = s8[7:0];
            r.ovf = s8[8];
         end
      endcase
      return r;
   endfunction : pair_step

   // Bus slave
   logic       rd_req;
   logic       wr_take;
   logic [7:0] idx;
   logic [7:0] wd;
   logic [7:0] rd_byte;

   // Registers
   logic [7:0]  timer_run_flag_control_q;
   logic [7:0]  timer_mode_select_q;
   logic [7:0]  t0_lo_q, t0_hi_q, t1_lo_q, t1_hi_q;
   logic [7:0]  pin_out_q;
   logic [7:0]  option_q;
   logic [7:0]  shared_flags_q;
   logic [5:0]  t2_ctrl_q;
   logic [15:0] t2_cnt_q;
   logic [15:0] t2_rcap_q;
   logic [7:0]  aux_q;

   // Pins and time base
   logic [PIN_COUNT-1:0] sync1_q, sync2_q, sync3_q, level_q;
   logic [PIN_COUNT-1:0] pin_fall, pin_rise;
   logic                 base_phase_q;
   logic                 base_tick;

   // Timer state
   pair_step_s  t0_nx, t1_nx;
   logic        t0_hi_ovf;
   logic        t0_inc, t1_inc, t0_hi_inc;
   logic        t1_run;
   logic        tf0_q, tf1_q, tf2_q, timer2_trigger_flag_q, tf3_q;
   logic        baud_t2, trig_act, t2_inc, t2_ovf;
   logic [15:0] t2_cnt_d, t2_rcap_d;
   logic [16:0] t3_cnt_q;
   logic [16:0] t3_period;
   logic        t3_src, t3_fire;
   logic [8:0]  frc_div_q;
   logic [4:0]  t0_out_cnt_q;

   assign idx     = i_avs_address[9:2];
   assign wd      = i_avs_writedata[7:0];
   assign rd_req  = i_avs_read && !i_avs_write;
   assign wr_take = i_avs_write && !o_avs_waitrequest_q && i_avs_byteenable[0];

   // Answer one cycle after the request is presented
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_avs_waitrequest_q <= 1'b1;
      end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest_q) begin
         o_avs_waitrequest_q <= 1'b0;
      end else begin
         o_avs_waitrequest_q <= 1'b1;
      end
   end

   always_comb begin
      case (idx)
         IDX_RUN_FLAG_CTRL:  rd_byte = {tf1_q, timer_run_flag_control_q[6], tf0_q, timer_run_flag_control_q[4:0]};
         IDX_MODE_SELECT:    rd_byte = timer_mode_select_q;
         IDX_T0_COUNT_LOW:   rd_byte = t0_lo_q;
         IDX_T1_COUNT_LOW:   rd_byte = t1_lo_q;
         IDX_T0_COUNT_HIGH:  rd_byte = t0_hi_q;
         IDX_T1_COUNT_HIGH:  rd_byte = t1_hi_q;
         IDX_PIN_OUT_ENABLE: rd_byte = pin_out_q;
         IDX_MISC_OPTION:    rd_byte = option_q;
         IDX_SHARED_FLAGS:   rd_byte = {shared_flags_q[7:1], tf3_q};
         IDX_T2_CONTROL:     rd_byte = {tf2_q, timer2_trigger_flag_q, t2_ctrl_q};
         IDX_T2_RCAP_LOW:    rd_byte = t2_rcap_q[7:0];
         IDX_T2_RCAP_HIGH:   rd_byte = t2_rcap_q[15:8];
         IDX_T2_COUNT_LOW:   rd_byte = t2_cnt_q[7:0];
         IDX_T2_COUNT_HIGH:  rd_byte = t2_cnt_q[15:8];
         IDX_AUX_CONTROL:    rd_byte = aux_q;
         default:            rd_byte = RST_BYTE_ZERO;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_avs_readdata_q <= 32'h00000000;
      end else if (rd_req && o_avs_waitrequest_q) begin
         o_avs_readdata_q <= {24'h000000, rd_byte};
      end
   end

   // Pin synchronisers; a level counts once stages two and three agree
   genvar gp;
   generate
      for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               sync1_q[gp] <= 1'b0;
               sync2_q[gp] <= 1'b0;
               sync3_q[gp] <= 1'b0;
               level_q[gp] <= 1'b0;
            end else begin
               sync1_q[gp] <= level_sel(gp);
               sync2_q[gp] <= sync1_q[gp];
               sync3_q[gp] <= sync2_q[gp];
               if (sync2_q[gp] == sync3_q[gp]) begin
                  level_q[gp] <= sync3_q[gp];
               end
            end
         end
         assign pin_fall[gp] = level_q[gp] && (sync2_q[gp] == sync3_q[gp]) && !sync3_q[gp];
         assign pin_rise[gp] = !level_q[gp] && (sync2_q[gp] == sync3_q[gp]) && sync3_q[gp];
      end
   endgenerate

   function automatic logic level_sel(input int n);
      logic [PIN_COUNT-1:0] v;
      v = {i_fast_rc_clock, i_slow_rc_clock, i_timer2_trigger_pin, i_timer2_count_pin,
           i_timer1_count_pin, i_timer0_count_pin, i_ext_irq1_pin, i_ext_irq0_pin};
      return v[n];
   endfunction : level_sel

   // Time base: one tick every two system clocks
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         base_phase_q <= 1'b0;
      end else begin
         base_phase_q <= !base_phase_q;
      end
   end
   assign base_tick = base_phase_q;

   // Control registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         timer_run_flag_control_q         <= RST_BYTE_ZERO;
         timer_mode_select_q         <= RST_BYTE_ZERO;
         pin_out_q      <= RST_BYTE_ZERO;
         option_q       <= RST_BYTE_ZERO;
         shared_flags_q <= RST_BYTE_ZERO;
         t2_ctrl_q      <= 6'h00;
         aux_q          <= RST_AUX_CONTROL;
      end else begin
         if (wr_take && idx == IDX_RUN_FLAG_CTRL)  timer_run_flag_control_q         <= wd;
         if (wr_take && idx == IDX_MODE_SELECT)    timer_mode_select_q         <= wd;
         if (wr_take && idx == IDX_PIN_OUT_ENABLE) pin_out_q      <= wd;
         if (wr_take && idx == IDX_MISC_OPTION)    option_q       <= wd;
         if (wr_take && idx == IDX_SHARED_FLAGS)   shared_flags_q <= wd;
         if (wr_take && idx == IDX_T2_CONTROL)     t2_ctrl_q      <= wd[5:0];
         if (wr_take && idx == IDX_AUX_CONTROL) begin
            aux_q <= wd;
         end else begin
            aux_q[BIT_T3_CLEAR] <= 1'b0;
         end
      end
   end

   // Timer0 and Timer1 counting
   assign t1_run = timer_run_flag_control_q[BIT_T1_RUN];
   always_comb begin
      t0_inc = timer_run_flag_control_q[BIT_T0_RUN]
               && (!timer_mode_select_q[BIT_T0_GATING] || level_q[PIN_IRQ0])
               && (timer_mode_select_q[BIT_T0_COUNT_SEL] ? pin_fall[PIN_T0] : base_tick);
      t1_inc = (timer_mode_select_q[LSB_T1_LAYOUT +: 2] != LAYOUT_SPLIT)
               && (t1_run || timer_mode_select_q[LSB_T0_LAYOUT +: 2] == LAYOUT_SPLIT)
               && (!timer_mode_select_q[BIT_T1_GATING] || level_q[PIN_IRQ1])
               && (timer_mode_select_q[BIT_T1_COUNT_SEL] ? pin_fall[PIN_T1] : base_tick);
      t0_hi_inc = (timer_mode_select_q[LSB_T0_LAYOUT +: 2] == LAYOUT_SPLIT) && t1_run && base_tick;
      t0_nx     = '{hi: t0_hi_q, lo: t0_lo_q, ovf: 1'b0};
      t0_hi_ovf = 1'b0;
      if (t0_inc) begin
         t0_nx = pair_step(timer_mode_select_q[LSB_T0_LAYOUT +: 2], t0_hi_q, t0_lo_q);
         t0_nx.hi = (timer_mode_select_q[LSB_T0_LAYOUT +: 2] == LAYOUT_SPLIT) ? t0_hi_q : t0_nx.hi;
      end
      if (t0_hi_inc) begin
         t0_nx.hi  = t0_hi_q + 8'h01;
         t0_hi_ovf = (t0_hi_q == 8'hFF);
      end
      t1_nx = '{hi: t1_hi_q, lo: t1_lo_q, ovf: 1'b0};
      if (t1_inc) begin
         t1_nx = pair_step(timer_mode_select_q[LSB_T1_LAYOUT +: 2], t1_hi_q, t1_lo_q);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         t0_lo_q <= RST_BYTE_ZERO;
         t0_hi_q <= RST_BYTE_ZERO;
         t1_lo_q <= RST_BYTE_ZERO;
         t1_hi_q <= RST_BYTE_ZERO;
      end else begin
         t0_lo_q <= (wr_take && idx == IDX_T0_COUNT_LOW)  ? wd : t0_nx.lo;
         t0_hi_q <= (wr_take && idx == IDX_T0_COUNT_HIGH) ? wd : t0_nx.hi;
         t1_lo_q <= (wr_take && idx == IDX_T1_COUNT_LOW)  ? wd : t1_nx.lo;
         t1_hi_q <= (wr_take && idx == IDX_T1_COUNT_HIGH) ? wd : t1_nx.hi;
      end
   end

   // Overflow flags; a hardware set wins over any clear
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tf0_q <= 1'b0;
         tf1_q <= 1'b0;
      end else begin
         if (t0_nx.ovf) begin
            tf0_q <= 1'b1;
         end else if (wr_take && idx == IDX_RUN_FLAG_CTRL) begin
            tf0_q <= wd[BIT_T0_OVF_FLAG];
         end else if (i_timer0_vector_ack) begin
            tf0_q <= 1'b0;
         end
         if (t0_hi_ovf || (t1_nx.ovf && timer_mode_select_q[LSB_T0_LAYOUT +: 2] != LAYOUT_SPLIT)) begin
            tf1_q <= 1'b1;
         end else if (wr_take && idx == IDX_RUN_FLAG_CTRL) begin
            tf1_q <= wd[BIT_T1_OVF_FLAG];
         end else if (i_timer1_vector_ack) begin
            tf1_q <= 1'b0;
         end
      end
   end

   // Timer2
   always_comb begin
      baud_t2   = t2_ctrl_q[BIT_RX_BAUD_T2] || t2_ctrl_q[BIT_TX_BAUD_T2];
      trig_act  = t2_ctrl_q[BIT_T2_TRIG_EN] && !baud_t2 && pin_fall[PIN_TRIG];
      t2_inc    = t2_ctrl_q[BIT_T2_RUN]
                  && (t2_ctrl_q[BIT_T2_COUNT_SEL] ? pin_fall[PIN_T2] : base_tick);
      t2_ovf    = t2_inc && (t2_cnt_q == 16'hFFFF);
      t2_cnt_d  = t2_inc ? t2_cnt_q + 16'h0001 : t2_cnt_q;
      t2_rcap_d = t2_rcap_q;
      if (t2_ovf && (baud_t2 || !t2_ctrl_q[BIT_T2_CAPTURE])) begin
         t2_cnt_d = t2_rcap_q;
      end
      if (trig_act && !t2_ctrl_q[BIT_T2_CAPTURE]) begin
         t2_cnt_d = t2_rcap_q;
      end
      if (trig_act && t2_ctrl_q[BIT_T2_CAPTURE]) begin
         t2_rcap_d = t2_cnt_q;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         t2_cnt_q  <= 16'h0000;
         t2_rcap_q <= 16'h0000;
      end else begin
         t2_cnt_q[7:0]   <= (wr_take && idx == IDX_T2_COUNT_LOW)  ? wd : t2_cnt_d[7:0];
         t2_cnt_q[15:8]  <= (wr_take && idx == IDX_T2_COUNT_HIGH) ? wd : t2_cnt_d[15:8];
         t2_rcap_q[7:0]  <= (wr_take && idx == IDX_T2_RCAP_LOW)   ? wd : t2_rcap_d[7:0];
         t2_rcap_q[15:8] <= (wr_take && idx == IDX_T2_RCAP_HIGH)  ? wd : t2_rcap_d[15:8];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tf2_q  <= 1'b0;
         timer2_trigger_flag_q <= 1'b0;
      end else begin
         if (t2_ovf && !baud_t2) begin
            tf2_q <= 1'b1;
         end else if (wr_take && idx == IDX_T2_CONTROL) begin
            tf2_q <= wd[BIT_T2_OVF_FLAG];
         end
         if (trig_act) begin
            timer2_trigger_flag_q <= 1'b1;
         end else if (wr_take && idx == IDX_T2_CONTROL) begin
            timer2_trigger_flag_q <= wd[BIT_T2_TRIG_FLAG];
         end
      end
   end

   // Timer3 time base
   always_comb begin
      case (option_q[LSB_T3_RATE +: 2])
         2'h0:    t3_period = T3_PERIOD_R0;
         2'h1:    t3_period = T3_PERIOD_R1;
         2'h2:    t3_period = T3_PERIOD_R2;
         default: t3_period = T3_PERIOD_R3;
      endcase
      t3_src  = option_q[BIT_T3_CLK_SEL] ? (pin_rise[PIN_FAST] && frc_div_q == FAST_RC_DIV_LAST)
                                         : pin_rise[PIN_SLOW];
      t3_fire = t3_src && (t3_cnt_q >= t3_period - 17'h00001);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         frc_div_q <= 9'h000;
      end else if (pin_rise[PIN_FAST]) begin
         frc_div_q <= frc_div_q + 9'h001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         t3_cnt_q <= 17'h00000;
      end else if (wr_take && idx == IDX_AUX_CONTROL && wd[BIT_T3_CLEAR]) begin
         t3_cnt_q <= 17'h00000;
      end else if (t3_fire) begin
         t3_cnt_q <= 17'h00000;
      end else if (t3_src) begin
         t3_cnt_q <= t3_cnt_q + 17'h00001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tf3_q <= 1'b0;
      end else if (t3_fire) begin
         tf3_q <= 1'b1;
      end else if (i_timer3_vector_ack) begin
         tf3_q <= 1'b0;
      end else if (wr_take && idx == IDX_SHARED_FLAGS && !wd[BIT_T3_FLAG]) begin
         tf3_q <= 1'b0;
      end
   end

   // Divided overflow outputs and baud ticks
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         t0_out_cnt_q          <= 5'h00;
         o_timer0_div64_out_q  <= 1'b0;
         o_timer2_div2_out_q   <= 1'b0;
         o_uart_rx_baud_tick_q <= 1'b0;
         o_uart_tx_baud_tick_q <= 1'b0;
      end else begin
         if (t0_nx.ovf) begin
            t0_out_cnt_q <= t0_out_cnt_q + 5'h01;
            if (t0_out_cnt_q == T0_OUT_HALF) begin
               o_timer0_div64_out_q <= !o_timer0_div64_out_q;
            end
         end
         if (t2_ovf) begin
            o_timer2_div2_out_q <= !o_timer2_div2_out_q;
         end
         o_uart_rx_baud_tick_q <= t2_ctrl_q[BIT_RX_BAUD_T2] ? t2_ovf : t1_nx.ovf;
         o_uart_tx_baud_tick_q <= t2_ctrl_q[BIT_TX_BAUD_T2] ? t2_ovf : t1_nx.ovf;
      end
   end

   assign o_timer0_overflow_flag_q = tf0_q;
   assign o_timer1_overflow_flag_q = tf1_q;
   assign o_timer2_overflow_flag_q = tf2_q;
   assign o_timer2_trigger_flag_q  = timer2_trigger_flag_q;
   assign o_timer3_period_flag_q   = tf3_q;
   assign o_timer0_div64_oe_q      = pin_out_q[BIT_T0_DIV64_OE];
   assign o_timer2_div2_oe_q       = pin_out_q[BIT_T2_DIV2_OE];

endmodule : quad_timer_counter_block

//--- bench/quad_timer_chk.sv
// Checker: bus handshake, flag clearing and pin output relations.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/1ps
module quad_timer_chk
   import quad_timer_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_rst_b,
   input wire logic [9:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic        o_avs_waitrequest_q,
   input wire logic        i_timer0_vector_ack,
   input wire logic        i_timer3_vector_ack,
   input wire logic        o_timer0_overflow_flag_q,
   input wire logic        o_timer2_overflow_flag_q,
   input wire logic        o_timer2_trigger_flag_q,
   input wire logic        o_timer3_period_flag_q,
   input wire logic        o_timer2_div2_out_q,
   input wire logic        o_uart_tx_baud_tick_q,
   input wire logic        o_uart_rx_baud_tick_q
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   logic wr_done;
   logic ctl_wr;
   logic t2_wr;
   logic t3_clr_wr;
   assign wr_done   = i_avs_write && !o_avs_waitrequest_q;
   assign ctl_wr    = wr_done && (i_avs_address[9:2] == IDX_RUN_FLAG_CTRL);
   assign t2_wr     = wr_done && (i_avs_address[9:2] == IDX_T2_CONTROL);
   assign t3_clr_wr = wr_done && (i_avs_address[9:2] == IDX_SHARED_FLAGS)
                      && !i_avs_writedata[BIT_T3_FLAG];
   a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest_q
      |=> !o_avs_waitrequest_q) else $error("no answer after one wait");
   a_wait_low_once: assert property (!o_avs_waitrequest_q |=> o_avs_waitrequest_q)
      else $error("wait low too long");
   a_t0_flag_clear: assert property (
      $fell(o_timer0_overflow_flag_q) |-> $past(i_timer0_vector_ack) || $past(ctl_wr))
      else $error("timer0 flag lost");
   a_t2_flag_sw: assert property (
      $fell(o_timer2_overflow_flag_q) |-> $past(t2_wr)) else $error("timer2 flag lost");
   a_trig_flag_sw: assert property (
      $fell(o_timer2_trigger_flag_q) |-> $past(t2_wr)) else $error("trigger flag lost");
   a_t3_flag_clear: assert property (
      $fell(o_timer3_period_flag_q) |-> $past(i_timer3_vector_ack) || $past(t3_clr_wr))
      else $error("timer3 flag lost");
   a_div2_toggles: assert property (
      $rose(o_timer2_overflow_flag_q) && !$past(t2_wr) |-> $changed(o_timer2_div2_out_q))
      else $error("div2 output missed overflow");
   a_tx_tick_pulse: assert property (
      o_uart_tx_baud_tick_q |=> !o_uart_tx_baud_tick_q) else $error("tx tick too long");
   a_rx_tick_pulse: assert property (
      o_uart_rx_baud_tick_q |=> !o_uart_rx_baud_tick_q) else $error("rx tick too long");
endmodule : quad_timer_chk
bind quad_timer_counter_block quad_timer_chk quad_timer_chk_i (.*);

//--- bench/ext_pin_model.sv
// Far-side pins: count and trigger pulses on request, free slow oscillator.
// Assumes requests are one-cycle pulses at least 12 cycles apart.
`timescale 1ns/1ps
module ext_pin_model (
   input  wire logic       i_ref_clk,
   input  wire logic [3:0] i_fire,
   output logic      [3:0] o_pins,
   output logic            o_osc
);
   logic [2:0] cnt_q [4];
   logic [1:0] div_q;
   initial begin
      o_osc = 1'b0;
      div_q = 2'h0;
      foreach (cnt_q[k]) cnt_q[k] = 3'h0;
   end
   // Oscillator period six system clocks
   always @(posedge i_ref_clk) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) o_osc <= ~o_osc;
   end
   for (genvar k = 0; k < 4; k++) begin : g_pin
      // Low pulse of four clocks
      always @(posedge i_ref_clk) begin
         cnt_q[k] <= i_fire[k] ? 3'h4 : ((cnt_q[k] != 3'h0) ? cnt_q[k] - 3'h1 : 3'h0);
      end
      assign o_pins[k] = (cnt_q[k] == 3'h0);
   end
endmodule : ext_pin_model

//--- bench/quad_timer_counter_block_bench.sv
// Self-checking bench for the quad timer block over its register bus.
// Assumes ext_pin_model drives the pins and the checker is bound.
`timescale 1ns/1ps
module quad_timer_counter_block_bench;
   import quad_timer_pkg::*;
   logic        clk, rst_b, rd, wr, wait_q, irq0, osc, f0, f2, ft, f3, d2, f1, d64;
   logic [1:0]  oe;
   logic [9:0]  addr;
   logic [31:0] wd, rdata;
   logic [1:0]  ack;
   logic [3:0]  fire, pins;
   logic [7:0]  q;
   int          bad_count, num_checks, n;
   logic [7:0]  ridx [6] = '{8'h88, 8'h89, 8'hC8, 8'h94, 8'hF8, 8'h00};
   logic [7:0]  rrst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h00};
   quad_timer_counter_block quad_timer_counter_block_i (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(4'hF), .o_avs_readdata_q(rdata), .o_avs_waitrequest_q(wait_q),
      .i_ext_irq0_pin(irq0), .i_ext_irq1_pin(1'b1), .i_timer0_count_pin(pins[0]),
      .i_timer1_count_pin(pins[1]), .i_timer2_count_pin(pins[2]),
      .i_timer2_trigger_pin(pins[3]), .i_slow_rc_clock(osc), .i_fast_rc_clock(osc),
      .i_timer0_vector_ack(ack[0]), .i_timer1_vector_ack(1'b0), .i_timer3_vector_ack(ack[1]),
      .o_timer0_overflow_flag_q(f0), .o_timer1_overflow_flag_q(f1), .o_timer2_overflow_flag_q(f2),
      .o_timer2_trigger_flag_q(ft), .o_timer3_period_flag_q(f3), .o_timer0_div64_out_q(d64),
      .o_timer0_div64_oe_q(oe[0]), .o_timer2_div2_out_q(d2), .o_timer2_div2_oe_q(oe[1]),
      .o_uart_rx_baud_tick_q(), .o_uart_tx_baud_tick_q());
   ext_pin_model ext_pin_model_i (.i_ref_clk(clk), .i_fire(fire), .o_pins(pins), .o_osc(osc));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task print_verdict;
      $display("Checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (e !== g) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      int k;
      @(posedge clk);
      addr <= {i, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wait_q !== 1'b0 && k < 50);
      if (k >= 50) begin
         bad_count++;
         print_verdict();
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task wrr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
   endtask : wrr
   task rdc(input logic [7:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk($sformatf("register %h", i), {24'h0, e}, {24'h0, q});
   endtask : rdc
   task pulse(input int k);
      fire[k] <= 1'b1;
      @(posedge clk);
      fire[k] <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : pulse
   initial begin
      rst_b = 1'b0; rd = 1'b0; wr = 1'b0; irq0 = 1'b0; addr = 10'h000; wd = 32'h0;
      ack = 2'h0; fire = 4'h0; bad_count = 0; num_checks = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      foreach (ridx[i]) rdc(ridx[i], rrst[i]);
      // Timer0 gated 16-bit, overflow after 16 ticks
      wrr(8'h8A, 8'hF0); wrr(8'h8C, 8'hFF); wrr(8'h89, 8'h09); wrr(8'h88, 8'h10);
      repeat (40) @(posedge clk); chk("t0 flag", 0, f0);
      irq0 <= 1'b1;
      repeat (28) @(posedge clk); chk("t0 flag", 0, f0);
      repeat (16) @(posedge clk); chk("t0 flag", 1, f0);
      ack[0] <= 1'b1; @(posedge clk); ack[0] <= 1'b0;
      repeat (2) @(posedge clk); chk("t0 flag", 0, f0);
      // Timer1 counting pin edges
      wrr(8'h88, 8'h00); wrr(8'h89, 8'h50); wrr(8'h88, 8'h40);
      repeat (5) pulse(1);
      rdc(8'h8B, 8'h05);
      // Reload layouts with high bytes FF: both overflow every tick
      wrr(8'h8A, 8'hFF); wrr(8'h8B, 8'hFF); wrr(8'h8C, 8'hFF); wrr(8'h8D, 8'hFF);
      wrr(8'h93, 8'h50); wrr(8'h89, 8'h22); wrr(8'h88, 8'h50);
      repeat (80) @(posedge clk); chk("div64 out", 1, d64);
      chk("t1 flag", 1, f1);
      chk("pin enables", 3, oe);
      rdc(8'h8A, 8'hFF);
      wrr(8'h88, 8'h00);
      // Timer2 reload, then forced reload with transmit baud select
      for (int m = 0; m < 2; m++) begin
         wrr(8'hCA, 8'h34); wrr(8'hCB, 8'h12); wrr(8'hCC, 8'hFE); wrr(8'hCD, 8'hFF);
         wrr(8'hC8, m ? 8'h17 : 8'h06);
         repeat (2) pulse(2);
         rdc(8'hCC, 8'h34);
         rdc(8'hCD, 8'h12);
         rdc(8'hC8, m ? 8'h17 : 8'h86);
         chk("div2 out", m ? 0 : 1, d2);
      end
      // Timer2 capture on trigger edge
      wrr(8'hC8, 8'h07); wrr(8'hCC, 8'h00); wrr(8'hCD, 8'h00);
      repeat (3) pulse(2); pulse(3);
      rdc(8'hC8, 8'h07);
      wrr(8'hC8, 8'h0F); pulse(3);
      rdc(8'hCA, 8'h03);
      rdc(8'hC8, 8'h4F);
      // Timer3 clear, period 8192 slow edges, software clear
      wrr(8'h94, 8'h02); wrr(8'hF8, 8'h4C); rdc(8'hF8, 8'h0C);
      wrr(8'h95, 8'hFE);
      n = 0;
      while (f3 !== 1'b1 && n < 50000) begin @(posedge clk); n++; end
      chk("t3 period", 1, n > 8192 * 6 - 80 && n < 8192 * 6 + 80);
      wrr(8'h95, 8'hFE); @(posedge clk); chk("t3 flag", 0, f3);
      print_verdict();
   end
endmodule : quad_timer_counter_block_bench
